// [eit_pkg.sv]
// constants and types shared by the interval timer unit, its host and prescaler
package eit_pkg;

    // device addresses on the link
    localparam logic [31:0] EIT_WR_ADDR     = 32'hffff8610;
    localparam logic [31:0] EIT_CSR_RD_ADDR = 32'hffff8610;
    localparam logic [31:0] EIT_CNT_RD_ADDR = 32'hffff8611;

    // write keys carried in the upper byte of a word write
    localparam logic [7:0]  EIT_KEY_CNT     = 8'h5a;
    localparam logic [7:0]  EIT_KEY_CSR     = 8'ha5;

    // interval_ctrl_status field positions
    localparam int          EIT_WRAP_BIT    = 7;
    localparam int          EIT_RUN_BIT     = 5;
    localparam int          EIT_SEL_MSB     = 2;

    // fixed bits: 4 and 3 read one, 6 reads zero
    localparam logic [7:0]  EIT_CSR_ONES    = 8'h18;
    localparam logic [7:0]  EIT_CSR_ZEROS   = 8'h40;

    // reset values and the counter maximum
    localparam logic [7:0]  EIT_CNT_RST     = 8'h00;
    localparam logic [7:0]  EIT_CNT_MAX     = 8'hff;
    localparam logic [2:0]  EIT_SEL_RST     = 3'h0;
    localparam logic [7:0]  EIT_BYTE_RST    = 8'h00;
    localparam logic [15:0] EIT_WORD_RST    = 16'h0000;
    localparam logic [31:0] EIT_BUS_RST     = 32'h00000000;

    // prescaler width and divide ratios
    localparam int          EIT_PRE_W       = 14;
    localparam logic [13:0] EIT_DIV_2       = 14'h0002;
    localparam logic [13:0] EIT_DIV_64      = 14'h0040;
    localparam logic [13:0] EIT_DIV_128     = 14'h0080;
    localparam logic [13:0] EIT_DIV_256     = 14'h0100;
    localparam logic [13:0] EIT_DIV_512     = 14'h0200;
    localparam logic [13:0] EIT_DIV_1024    = 14'h0400;
    localparam logic [13:0] EIT_DIV_4096    = 14'h1000;
    localparam logic [13:0] EIT_DIV_8192    = 14'h2000;
    localparam logic [13:0] EIT_PRE_RST     = 14'h0000;
    localparam logic [13:0] EIT_PRE_ONE     = 14'h0001;

    // host register byte offsets
    localparam logic [4:0]  EIT_H_CNT_OFS   = 5'h00;
    localparam logic [4:0]  EIT_H_CSR_OFS   = 5'h04;
    localparam logic [4:0]  EIT_H_RD_OFS    = 5'h08;
    localparam logic [4:0]  EIT_H_STAT_OFS  = 5'h0c;
    localparam logic [4:0]  EIT_H_MASK_OFS  = 5'h10;

    // host event bits
    localparam int          EIT_EV_TIMER    = 0;
    localparam int          EIT_EV_RDONE    = 1;
    localparam logic [1:0]  EIT_EV_RST      = 2'h0;

    // transfer size on the link
    typedef enum logic [1:0] {
        EIT_SZ_BYTE = 2'b00,
        EIT_SZ_WORD = 2'b01,
        EIT_SZ_LONG = 2'b10
    } eit_size_t;

    // host sequencer states
    typedef enum logic [1:0] {
        EIT_H_IDLE  = 2'b00,
        EIT_H_SEND  = 2'b01,
        EIT_H_RWAIT = 2'b10
    } eit_hstate_t;

    // last prescaler count value for a divider select
    function automatic logic [13:0] eit_div_last(input logic [2:0] sel);
        logic [13:0] div;
        div = EIT_DIV_2;
        case (sel)
            3'h0: div = EIT_DIV_2;
            3'h1: div = EIT_DIV_64;
            3'h2: div = EIT_DIV_128;
            3'h3: div = EIT_DIV_256;
            3'h4: div = EIT_DIV_512;
            3'h5: div = EIT_DIV_1024;
            3'h6: div = EIT_DIV_4096;
            default: div = EIT_DIV_8192;
        endcase
        return div - EIT_PRE_ONE;
    endfunction

endpackage

// [eit_if.sv]
// link between the cpu-side host and the interval timer unit
`timescale 1ns/1ps
interface eit_if;
    import eit_pkg::*;

    logic        wr;
    logic        rd;
    logic [31:0] addr;
    eit_size_t   size;
    logic [15:0] wdata;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        irq;

    modport dev (
        input  wr,
        input  rd,
        input  addr,
        input  size,
        input  wdata,
        output rdata,
        output rvalid,
        output irq
    );

    modport cpu (
        output wr,
        output rd,
        output addr,
        output size,
        output wdata,
        input  rdata,
        input  rvalid,
        input  irq
    );
endinterface

// [eit_prescaler.sv]
// prescaler producing the counter tick from the system clock
`timescale 1ns/1ps
module eit_prescaler
    import eit_pkg::*;
#(
    parameter int W = EIT_PRE_W
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // control
    input  wire logic       run,
    input  wire logic [2:0] sel,
    // tick out
    output wire logic       tick
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } eit_pre_state_t;

    eit_pre_state_t st_reg;
    eit_pre_state_t st_next;
    logic [W-1:0]   last;

    assign last = W'(eit_div_last(sel));
    assign tick = st_reg.tick;

    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (!run) begin
            // held cleared so a fresh enable waits a full period
            st_next.cnt = W'(EIT_PRE_RST);
        end else if (st_reg.cnt >= last) begin
            st_next.cnt  = W'(EIT_PRE_RST);
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + W'(EIT_PRE_ONE);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

// [eit_timer_dev.sv]
// interval timer unit: 8-bit wrap counter with keyed word writes and byte reads
//
// Behaviour
// - counter increments per prescaled tick while enabled
// - wrap to zero raises interrupt, keeps counting
// - counter zero at reset and while disabled
// - flag, enable, divider select cleared at reset
// - bits 4,3 read one; bit 6 zero
// - flag and interrupt set on same cycle
// - flag clears by zero write after one-read
// - select picks divide 2..8192 tick
// - writes only as 16-bit words
// - key 0x5a word loads the counter
// - key 0xa5 word loads control/status
// - status at low address, counter next byte
// - reads only as single bytes
// - counter write beats a coinciding tick
// - stop timer before changing divider select
`timescale 1ns/1ps
module eit_timer_dev
    import eit_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // link to the host
    eit_if.dev        bus,
    // user side status
    output wire logic interval_irq,
    output wire logic count_run_enable,
    output wire logic [7:0] interval_count
);

    typedef struct packed {
        logic [7:0] cnt;
        logic       wrap_flag;
        logic       run;
        logic [2:0] sel;
        logic       armed;
        logic       irq;
        logic [7:0] rdata;
        logic       rvalid;
    } eit_dev_state_t;

    eit_dev_state_t st_reg;
    eit_dev_state_t st_next;

    logic       tick;
    logic       wr_word;
    logic       load_cnt;
    logic       load_csr;
    logic       rd_csr;
    logic       rd_cnt;
    logic       stepping;
    logic       wrap;
    logic [7:0] csr_view;
    logic [7:0] wr_low;

    // prescaler runs only while the counter is enabled
    eit_prescaler #(
        .W        (EIT_PRE_W)
    ) u_pre (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .run      (st_reg.run),
        .sel      (st_reg.sel),
        .tick     (tick)
    );

    // write decode: only word writes to the shared address count
    assign wr_word  = bus.wr && (bus.size == EIT_SZ_WORD)
                      && (bus.addr == EIT_WR_ADDR);
    assign wr_low   = bus.wdata[7:0];

    // the key in the upper byte picks the target, else nothing happens
    assign load_cnt = wr_word && (bus.wdata[15:8] == EIT_KEY_CNT);
    assign load_csr = wr_word && (bus.wdata[15:8] == EIT_KEY_CSR);

    // read decode by byte address
    assign rd_csr   = bus.rd && (bus.addr == EIT_CSR_RD_ADDR);
    assign rd_cnt   = bus.rd && (bus.addr == EIT_CNT_RD_ADDR);

    // an increment happens on a tick unless a counter load owns the cycle
    assign stepping = st_reg.run && tick && !load_cnt;
    assign wrap     = stepping && (st_reg.cnt == EIT_CNT_MAX);

    // status byte as software sees it
    always_comb begin
        csr_view                          = EIT_CSR_ONES;
        csr_view[EIT_WRAP_BIT]            = st_reg.wrap_flag;
        csr_view[EIT_RUN_BIT]             = st_reg.run;
        csr_view[EIT_SEL_MSB:0]           = st_reg.sel;
    end

    always_comb begin
        st_next = st_reg;

        // counter path
        if (load_cnt) begin
            st_next.cnt = wr_low;
        end else if (stepping) begin
            st_next.cnt = st_reg.cnt + 8'h01;
        end
        if (!st_reg.run) begin
            st_next.cnt = EIT_CNT_RST;
        end

        // control/status write: fixed bits are not stored
        if (load_csr) begin
            st_next.run = wr_low[EIT_RUN_BIT];
            st_next.sel = wr_low[EIT_SEL_MSB:0];
            // a zero clears only after the flag was read as one
            if (!wr_low[EIT_WRAP_BIT] && st_reg.armed) begin
                st_next.wrap_flag = 1'b0;
                st_next.armed     = 1'b0;
            end
        end

        // a status read showing the flag set arms the clear
        if (rd_csr && st_reg.wrap_flag) begin
            st_next.armed = 1'b1;
        end

        // wrap sets the flag, winning over a clear in the same cycle
        if (wrap) begin
            st_next.wrap_flag = 1'b1;
        end

        // interrupt registered together with the flag
        st_next.irq = st_next.wrap_flag;

        // byte read answer, one cycle after the request
        st_next.rvalid = bus.rd;
        if (rd_csr) begin
            st_next.rdata = csr_view;
        end else if (rd_cnt) begin
            st_next.rdata = st_reg.cnt;
        end else if (bus.rd) begin
            st_next.rdata = EIT_BYTE_RST;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg.cnt       <= EIT_CNT_RST;
            st_reg.wrap_flag <= 1'b0;
            st_reg.run       <= 1'b0;
            st_reg.sel       <= EIT_SEL_RST;
            st_reg.armed     <= 1'b0;
            st_reg.irq       <= 1'b0;
            st_reg.rdata     <= EIT_BYTE_RST;
            st_reg.rvalid    <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign bus.rdata        = st_reg.rdata;
    assign bus.rvalid       = st_reg.rvalid;
    assign bus.irq          = st_reg.irq;
    assign interval_irq     = st_reg.irq;
    assign count_run_enable = st_reg.run;
    assign interval_count   = st_reg.cnt;

endmodule

// [eit_timer_host.sv]
// host end: avalon-mm slave that drives keyed writes and byte reads to the timer
`timescale 1ns/1ps
module eit_timer_host
    import eit_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output wire logic [31:0] avs_readdata,
    output wire logic        avs_waitrequest,
    // interrupt
    output wire logic        irq,
    // link to the timer
    eit_if.cpu               bus
);

    typedef struct packed {
        eit_hstate_t state;
        logic        waitreq;
        logic [31:0] rdata;
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        eit_size_t   size;
        logic [15:0] wdata;
        logic [15:0] pend;
        logic [7:0]  shadow;
        logic [7:0]  last_rd;
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic        prev_irq;
        logic        irq;
    } eit_host_state_t;

    eit_host_state_t st_reg;
    eit_host_state_t st_next;

    logic       req;
    logic       link_cmd;
    logic [7:0] csr_word;
    logic [7:0] stop_word;
    logic [1:0] ev;

    assign req      = avs_read || avs_write;
    assign link_cmd = avs_write && ((avs_address == EIT_H_CNT_OFS)
                      || (avs_address == EIT_H_CSR_OFS) || (avs_address == EIT_H_RD_OFS));
    // fixed bits forced to their only legal values
    assign csr_word = (avs_writedata[7:0] | EIT_CSR_ONES) & ~EIT_CSR_ZEROS;
    // stop word: enable off, flag bit one so the flag is untouched
    always_comb begin
        stop_word               = st_reg.shadow;
        stop_word[EIT_RUN_BIT]  = 1'b0;
        stop_word[EIT_WRAP_BIT] = 1'b1;
    end

    always_comb begin
        st_next      = st_reg;
        st_next.wr   = 1'b0;
        st_next.rd   = 1'b0;
        ev           = EIT_EV_RST;
        if (req && st_reg.waitreq) begin
            // answer when the link is free for a command
            if (!link_cmd || (st_reg.state == EIT_H_IDLE)) begin
                st_next.waitreq = 1'b0;
                if (avs_address == EIT_H_CSR_OFS) begin
                    st_next.rdata = {24'h000000, st_reg.shadow};
                end else if (avs_address == EIT_H_RD_OFS) begin
                    st_next.rdata = {23'h000000, st_reg.state != EIT_H_IDLE, st_reg.last_rd};
                end else if (avs_address == EIT_H_STAT_OFS) begin
                    st_next.rdata = {30'h00000000, st_reg.stat};
                end else if (avs_address == EIT_H_MASK_OFS) begin
                    st_next.rdata = {30'h00000000, st_reg.mask};
                end else begin
                    st_next.rdata = EIT_BUS_RST;
                end
            end
        end else if (req) begin
            st_next.waitreq = 1'b1;
            if (avs_write) begin
                if (avs_address == EIT_H_CNT_OFS) begin
                    st_next.wr    = 1'b1;
                    st_next.addr  = EIT_WR_ADDR;
                    st_next.size  = EIT_SZ_WORD;
                    st_next.wdata = {EIT_KEY_CNT, avs_writedata[7:0]};
                end else if (avs_address == EIT_H_CSR_OFS) begin
                    st_next.wr     = 1'b1;
                    st_next.addr   = EIT_WR_ADDR;
                    st_next.size   = EIT_SZ_WORD;
                    st_next.shadow = csr_word;
                    if (st_reg.shadow[EIT_RUN_BIT]
                        && (csr_word[EIT_SEL_MSB:0] != st_reg.shadow[EIT_SEL_MSB:0])) begin
                        // halt first, then send the new select
                        st_next.wdata = {EIT_KEY_CSR, stop_word};
                        st_next.pend  = {EIT_KEY_CSR, csr_word};
                        st_next.state = EIT_H_SEND;
                    end else begin
                        st_next.wdata = {EIT_KEY_CSR, csr_word};
                    end
                end else if (avs_address == EIT_H_RD_OFS) begin
                    st_next.rd    = 1'b1;
                    st_next.size  = EIT_SZ_BYTE;
                    st_next.addr  = avs_writedata[0] ? EIT_CNT_RD_ADDR : EIT_CSR_RD_ADDR;
                    st_next.state = EIT_H_RWAIT;
                end else if (avs_address == EIT_H_STAT_OFS) begin
                    st_next.stat = st_reg.stat & ~avs_writedata[1:0];
                end else if (avs_address == EIT_H_MASK_OFS) begin
                    st_next.mask = avs_writedata[1:0];
                end
            end
        end

        case (st_reg.state)
            EIT_H_SEND: begin
                st_next.wr    = 1'b1;
                st_next.wdata = st_reg.pend;
                st_next.state = EIT_H_IDLE;
            end
            EIT_H_RWAIT: begin
                if (bus.rvalid) begin
                    st_next.last_rd      = bus.rdata;
                    ev[EIT_EV_RDONE]     = 1'b1;
                    st_next.state        = EIT_H_IDLE;
                end
            end
            default: begin
            end
        endcase

        // sticky events; a set beats a clear in the same cycle
        ev[EIT_EV_TIMER] = bus.irq && !st_reg.prev_irq;
        st_next.prev_irq = bus.irq;
        st_next.stat     = st_next.stat | ev;
        st_next.irq      = |(st_next.stat & st_next.mask);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg         <= '0;
            st_reg.state   <= EIT_H_IDLE;
            st_reg.waitreq <= 1'b1;
            st_reg.size    <= EIT_SZ_BYTE;
            st_reg.shadow  <= EIT_CSR_ONES;
        end else begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata    = st_reg.rdata;
    assign avs_waitrequest = st_reg.waitreq;
    assign irq             = st_reg.irq;
    assign bus.wr          = st_reg.wr;
    assign bus.rd          = st_reg.rd;
    assign bus.addr        = st_reg.addr;
    assign bus.size        = st_reg.size;
    assign bus.wdata       = st_reg.wdata;

endmodule

// [eit_timer_host_end_marker.sv]
// intentionally empty compilation unit
`timescale 1ns/1ps

// [eit_timer_props.sv]
// link checker for the interval timer host and device pair
`timescale 1ns/1ps
module eit_timer_props
    import eit_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        arst_n,
    // link signals
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] addr,
    input wire eit_size_t   size,
    input wire logic [15:0] wdata,
    input wire logic [7:0]  rdata,
    input wire logic        rvalid,
    input wire logic        irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_csr_wr;
        wr && size == EIT_SZ_WORD && wdata[15:8] == EIT_KEY_CSR;
    endsequence

    AST_RD_ANSWER: assert property (rd |=> rvalid)
        else $error("read not answered next cycle");
    AST_RVALID_CAUSE: assert property (rvalid |-> $past(rd))
        else $error("answer without read");
    AST_CSR_FIXED_READ: assert property ((rd && addr == EIT_CSR_RD_ADDR) |=>
        (rdata[4:3] == 2'b11 && !rdata[6])) else $error("fixed status bits wrong");
    AST_WR_WORD: assert property (wr |-> size == EIT_SZ_WORD && addr == EIT_WR_ADDR)
        else $error("write not a word at the write address");
    AST_RD_BYTE: assert property (rd |-> size == EIT_SZ_BYTE)
        else $error("read not byte wide");
    AST_WR_FIXED_BITS: assert property (s_csr_wr |-> wdata[4:3] == 2'b11 && !wdata[6])
        else $error("status write with wrong fixed bits");
    AST_STOP_BEFORE_SEL: assert property (s_csr_wr ##1 s_csr_wr |-> !$past(wdata[5]))
        else $error("select changed while running");
    AST_IRQ_CLEAR_CAUSE: assert property ($fell(irq) |->
        $past(wr && wdata[15:8] == EIT_KEY_CSR && !wdata[EIT_WRAP_BIT]))
        else $error("flag cleared without a zero write");
    AST_IRQ_ONE_KEEPS: assert property ((irq && wr && wdata[15:8] == EIT_KEY_CSR &&
        wdata[EIT_WRAP_BIT]) |=> irq) else $error("writing one cleared the flag");
endmodule

// [eight_bit_interval_timer_test.sv]
// self-checking bench joining the host and timer ends
`timescale 1ns/1ps
module eight_bit_interval_timer_test
    import eit_pkg::*;
;
    logic        core_clk;
    logic        arst_n;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest;
    wire         irq;
    wire         interval_irq;
    wire         count_run_enable;
    wire  [7:0]  interval_count;
    int          failures;
    int          samples_checked;
    int          cycles;
    int          n;
    int          div_tab[8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] rd_val;
    logic [7:0]  v;

    eit_if eit_if_i ();
    eit_timer_host eit_timer_host_i (.core_clk(core_clk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .bus(eit_if_i));
    eit_timer_dev eit_timer_dev_i (.core_clk(core_clk), .arst_n(arst_n), .bus(eit_if_i),
        .interval_irq(interval_irq), .count_run_enable(count_run_enable),
        .interval_count(interval_count));
    eit_timer_props eit_timer_props_i (.core_clk(core_clk), .arst_n(arst_n),
        .wr(eit_if_i.wr), .rd(eit_if_i.rd), .addr(eit_if_i.addr), .size(eit_if_i.size),
        .wdata(eit_if_i.wdata), .rdata(eit_if_i.rdata), .rvalid(eit_if_i.rvalid),
        .irq(eit_if_i.irq));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
        samples_checked++;
        if ((got & msk) !== (exp & msk)) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one avalon access, held until waitrequest is seen low
    task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= d;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd_val = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        av(1'b0, a, 32'h0);
    endtask

    // link read of status (sel 0) or counter (sel 1), then compare the byte
    task automatic dev_rd(input logic sel, input logic [7:0] e);
        int k;
        av(1'b1, EIT_H_RD_OFS, {31'h0, sel});
        k = 0;
        do begin
            rd(EIT_H_RD_OFS, 32'h0, 32'h0);
            k++;
        end while (rd_val[8] !== 1'b0 && k < 20);
        rd(EIT_H_RD_OFS, {24'h0, e}, 32'hff);
    endtask

    task automatic measure(output int c);
        logic [7:0] s;
        s = interval_count;
        c = 0;
        do begin
            @(posedge core_clk);
            c++;
        end while (interval_count === s);
    endtask

    // read results compared against the oldest note
    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            if (msk_q[0] != 32'h0)
                chk(avs_readdata, exp_q[0], msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            print_verdict();
        end
    end

    initial begin
        arst_n        = 1'b0;
        avs_address   = 5'h00;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
        void'($urandom(32'hc2e9));
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(EIT_H_CSR_OFS, 32'h18, 32'hffffffff);
        dev_rd(1'b0, 8'h18);
        dev_rd(1'b1, 8'h00);
        rd(5'h14, 32'h0, 32'hffffffff);
        av(1'b1, 5'h1c, 32'hffffffff);
        $display("reset values done");
        v = 8'($urandom) & 8'h5f;
        av(1'b1, EIT_H_CSR_OFS, {24'h0, v});
        dev_rd(1'b0, (v & 8'h07) | 8'h18);
        av(1'b1, EIT_H_CNT_OFS, 32'h55);
        dev_rd(1'b1, 8'h00);
        $display("fixed bits and disabled counter done");
        av(1'b1, EIT_H_CSR_OFS, 32'h20);
        v = 8'hf0 + (8'($urandom) & 8'h0f);
        av(1'b1, EIT_H_CNT_OFS, {24'h0, v});
        @(posedge core_clk);
        #1;
        chk(interval_count, v, 32'hff);
        chk(count_run_enable, 1'b1, 32'h1);
        n = 0;
        while (interval_count !== 8'h00 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        chk(interval_irq, 1'b1, 32'h1);
        chk(eit_if_i.irq, 1'b1, 32'h1);
        measure(n);
        chk(interval_count, 8'h01, 32'hff);
        $display("load and wrap done");
        av(1'b1, EIT_H_MASK_OFS, 32'h1);
        repeat (3) @(posedge core_clk);
        chk(irq, 1'b1, 32'h1);
        rd(EIT_H_STAT_OFS, 32'h1, 32'h1);
        av(1'b1, EIT_H_MASK_OFS, 32'h0);
        repeat (3) @(posedge core_clk);
        chk(irq, 1'b0, 32'h1);
        av(1'b1, EIT_H_STAT_OFS, 32'h3);
        rd(EIT_H_STAT_OFS, 32'h0, 32'h1);
        $display("host interrupt done");
        av(1'b1, EIT_H_CSR_OFS, 32'h00);
        repeat (3) @(posedge core_clk);
        chk(interval_irq, 1'b1, 32'h1);
        chk(interval_count, 8'h00, 32'hff);
        dev_rd(1'b0, 8'h98);
        av(1'b1, EIT_H_CSR_OFS, 32'h80);
        repeat (3) @(posedge core_clk);
        chk(interval_irq, 1'b1, 32'h1);
        av(1'b1, EIT_H_CSR_OFS, 32'h00);
        repeat (3) @(posedge core_clk);
        chk(interval_irq, 1'b0, 32'h1);
        $display("flag clear done");
        for (int s = 0; s < 8; s++) begin
            av(1'b1, EIT_H_CSR_OFS, 32'h20 | s);
            repeat (4) @(posedge core_clk);
            measure(n);
            measure(n);
            chk(n, div_tab[s], 32'hffffffff);
        end
        $display("divider periods done");
        print_verdict();
    end
endmodule
